// [rtl/asp_serial_port_consts.vh]
// register map, field positions, reset values and divider counts
// assumes: included by the serial port design file only
`ifndef ASP_SERIAL_PORT_CONSTS_VH
`define ASP_SERIAL_PORT_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ASP_OFS_CTRL   3'h0
`define ASP_OFS_BUF    3'h1
`define ASP_OFS_STAT   3'h2
`define ASP_OFS_MASK   3'h3
`define ASP_OFS_BAUD   3'h4

// ----------------------------------------
// control fields
// ----------------------------------------
`define ASP_CTRL_MODE_HI  7
`define ASP_CTRL_MODE_LO  6
`define ASP_CTRL_MPEN     5
`define ASP_CTRL_REN      4
`define ASP_CTRL_TX_NINTH 3
`define ASP_CTRL_RX_NINTH 2
`define ASP_CTRL_SMOD     1
`define ASP_CTRL_RST      8'h00

// ----------------------------------------
// status / mask fields
// ----------------------------------------
`define ASP_ST_RXDONE  0
`define ASP_ST_TXDONE  1
`define ASP_ST_OVR     2
`define ASP_STAT_RST   3'h0
`define ASP_MASK_RST   3'h0
`define ASP_BAUD_RST   8'h00

// ----------------------------------------
// modes
// ----------------------------------------
`define ASP_MODE_SHIFT 2'h0
`define ASP_MODE_ASY10 2'h1
`define ASP_MODE_FIX11 2'h2
`define ASP_MODE_VAR11 2'h3

// ----------------------------------------
// timing counts: mode 0 phases and mode 2 limits in clk_sys cycles, bit phases in oversample ticks
// ----------------------------------------
`define ASP_M0_LAST    4'hb
`define ASP_M0_HALF    4'h5
`define ASP_M0_SAMPLE  4'hb
`define ASP_OS_LAST    4'hf
`define ASP_OS_MID     4'h7
`define ASP_M2_LIM32   8'h01
`define ASP_M2_LIM64   8'h03

`endif

// [rtl/asp_serial_port.v]
// four mode serial port: shift register mode and three async frame modes
// assumes: clk_sys 40 MHz, CPU on a plain strobe port, rxd/txd pins outside
//
// Functional notes
// - in modes 1 to 3 transmit and receive paths run independently and at the same time; mode 0 shares one shift engine.
// - receive shifter is separate from receive buffer, so new frame may start.
// - frame completing while receive done flag still set is dropped, overrun flag set.
// - buffer write loads transmit shifter; buffer read returns receive buffer.
// - mode 0 shifts 8 bits lsb first on rxd, clock on txd, clk/12.
// - mode 1 frame is start 0, 8 data bits lsb first, stop 1.
// - mode 1 reception stores received stop bit into rx ninth bit.
// - mode 2 frame adds tx ninth bit before stop bit, 11 bits total.
// - modes 2 and 3 store received ninth bit; stop bit ignored.
// - mode 2 bit rate is clk/32 or clk/64 by select bit.
// - mode 3 equals mode 2 framing with variable bit rate.
// - any buffer write starts a transmission in every mode.
// - mode 0 reception starts when receive done is 0 and enable is 1.
// - modes 1 to 3 start reception on start bit while enable is set.
// - multiprocessor filter in modes 2/3 accepts only frames with ninth bit 1.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "asp_serial_port_consts.vh"

module asp_serial_port (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire [2:0] addr,
    input  wire [7:0] wr_data,
    input  wire       wr_en,
    input  wire       rd_en,
    output reg  [7:0] rd_data,
    input  wire       rxd_in,
    output reg        rxd_out,
    output reg        rxd_oe,
    output reg        txd,
    output reg        irq
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0] ctrl;
    wire [2:0] stat;
    reg  [2:0] mask;
    reg  [7:0] baud;
    reg  [7:0] rx_buf;
    reg        rx_ninth_bit;

    wire [1:0] mode      = ctrl[`ASP_CTRL_MODE_HI:`ASP_CTRL_MODE_LO];
    wire       mp_en     = ctrl[`ASP_CTRL_MPEN];
    wire       rx_en     = ctrl[`ASP_CTRL_REN];
    wire       tx_ninth  = ctrl[`ASP_CTRL_TX_NINTH];
    wire       smod      = ctrl[`ASP_CTRL_SMOD];
    wire       buf_wr    = wr_en && (addr == `ASP_OFS_BUF);
    wire       mode0     = (mode == `ASP_MODE_SHIFT);

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    // ten bit frame; the other async modes carry a ninth bit
    function is_short_frame;
        input [1:0] m;
        begin
            is_short_frame = (m == `ASP_MODE_ASY10);
        end
    endfunction

    // ----------------------------------------
    // rxd input synchroniser
    // ----------------------------------------
    reg        rx_s1;
    reg        rx_s2;
    reg        rx_s3;
    reg        rx_line;
    reg        rx_line_d;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1     <= 1'b1;
            rx_s2     <= 1'b1;
            rx_s3     <= 1'b1;
            rx_line   <= 1'b1;
            rx_line_d <= 1'b1;
        end else begin
            rx_s1     <= rxd_in;
            rx_s2     <= rx_s1;
            rx_s3     <= rx_s2;
            // glitch of one cycle never reaches the line
            if (rx_s2 == rx_s3)
                rx_line <= rx_s3;
            rx_line_d <= rx_line;
        end
    end

    // ----------------------------------------
    // 16x oversample tick
    // ----------------------------------------
    reg  [7:0] os_cnt;
    reg        os_tick;
    wire [7:0] os_lim = (mode == `ASP_MODE_FIX11) ?
                        (smod ? `ASP_M2_LIM32 : `ASP_M2_LIM64) : baud;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            os_cnt  <= 8'h00;
            os_tick <= 1'b0;
        end else begin
            os_tick <= (os_cnt >= os_lim);
            if (os_cnt >= os_lim)
                os_cnt <= 8'h00;
            else
                os_cnt <= os_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // async transmitter, modes 1 to 3
    // ----------------------------------------
    reg        tx_busy;
    reg [10:0] tx_sh;
    reg  [3:0] tx_bits;
    reg  [3:0] tx_os;
    reg        tx_line;
    reg        atx_evt;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy <= 1'b0;
            tx_sh   <= 11'h7ff;
            tx_bits <= 4'h0;
            tx_os   <= 4'h0;
            tx_line <= 1'b1;
            atx_evt <= 1'b0;
        end else begin
            atx_evt <= 1'b0;
            if (buf_wr && !mode0) begin
                if (is_short_frame(mode)) begin
                    tx_sh   <= {2'h3, wr_data, 1'b0};
                    tx_bits <= 4'ha;
                end else begin
                    tx_sh   <= {1'b1, tx_ninth, wr_data, 1'b0};
                    tx_bits <= 4'hb;
                end
                tx_os   <= 4'h0;
                tx_busy <= 1'b1;
            end else if (tx_busy && os_tick) begin
                tx_os <= tx_os + 4'h1;
                if (tx_os == `ASP_OS_LAST) begin
                    tx_sh   <= {1'b1, tx_sh[10:1]};
                    tx_bits <= tx_bits - 4'h1;
                    if (tx_bits == 4'h1) begin
                        tx_busy <= 1'b0;
                        atx_evt <= 1'b1;
                    end
                end
            end
            tx_line <= tx_busy ? tx_sh[0] : 1'b1;
        end
    end

    // ----------------------------------------
    // async receiver, modes 1 to 3
    // ----------------------------------------
    reg        rx_busy;
    reg  [3:0] rx_os;
    reg  [3:0] rx_bits;
    reg [10:0] rx_sh;
    reg        arx_evt;
    reg  [7:0] arx_data;
    reg        arx_ninth;
    wire [10:0] rx_nsh  = {rx_line, rx_sh[10:1]};
    wire [3:0]  rx_last = is_short_frame(mode) ? 4'h9 : 4'ha;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_busy   <= 1'b0;
            rx_os     <= 4'h0;
            rx_bits   <= 4'h0;
            rx_sh     <= 11'h000;
            arx_evt   <= 1'b0;
            arx_data  <= 8'h00;
            arx_ninth <= 1'b0;
        end else begin
            arx_evt <= 1'b0;
            if (!rx_busy) begin
                // start bit edge, only while enabled
                if (rx_en && !mode0 && rx_line_d && !rx_line) begin
                    rx_busy <= 1'b1;
                    rx_os   <= 4'h0;
                    rx_bits <= 4'h0;
                end
            end else if (mode0) begin
                rx_busy <= 1'b0;
            end else if (os_tick) begin
                rx_os <= rx_os + 4'h1;
                if (rx_os == `ASP_OS_MID) begin
                    rx_sh   <= rx_nsh;
                    rx_bits <= rx_bits + 4'h1;
                    if (rx_bits == 4'h0 && rx_line) begin
                        // false start: line back high at mid bit
                        rx_busy <= 1'b0;
                    end else if (rx_bits == rx_last) begin
                        rx_busy <= 1'b0;
                        arx_evt <= 1'b1;
                        if (is_short_frame(mode)) begin
                            arx_data  <= rx_nsh[9:2];
                            arx_ninth <= rx_nsh[10];
                        end else begin
                            arx_data  <= rx_nsh[8:1];
                            arx_ninth <= rx_nsh[9];
                        end
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // mode 0 shift engine
    // ----------------------------------------
    reg        m0_busy;
    reg        m0_tx;
    reg  [3:0] m0_ph;
    reg  [2:0] m0_bit;
    reg  [7:0] m0_sh;
    reg        m0_clk;
    reg        m0_tx_evt;
    reg        m0_rx_evt;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            m0_busy   <= 1'b0;
            m0_tx     <= 1'b0;
            m0_ph     <= 4'h0;
            m0_bit    <= 3'h0;
            m0_sh     <= 8'h00;
            m0_clk    <= 1'b1;
            m0_tx_evt <= 1'b0;
            m0_rx_evt <= 1'b0;
            rxd_out   <= 1'b1;
            rxd_oe    <= 1'b0;
        end else begin
            m0_tx_evt <= 1'b0;
            m0_rx_evt <= 1'b0;
            if (mode0 && buf_wr) begin
                m0_busy <= 1'b1;
                m0_tx   <= 1'b1;
                m0_sh   <= wr_data;
                m0_ph   <= 4'h0;
                m0_bit  <= 3'h0;
            end else if (!m0_busy) begin
                // guard on the event: flag lands one cycle after done
                if (mode0 && rx_en && !stat[`ASP_ST_RXDONE] && !m0_rx_evt) begin
                    m0_busy <= 1'b1;
                    m0_tx   <= 1'b0;
                    m0_ph   <= 4'h0;
                    m0_bit  <= 3'h0;
                end
            end else if (!mode0) begin
                m0_busy <= 1'b0;
            end else begin
                if (m0_ph == `ASP_M0_LAST)
                    m0_ph <= 4'h0;
                else
                    m0_ph <= m0_ph + 4'h1;
                // pin reaches rx_line about five cycles late: sample at end of high phase
                if (!m0_tx && m0_ph == `ASP_M0_SAMPLE)
                    m0_sh <= {rx_line, m0_sh[7:1]};
                if (m0_ph == `ASP_M0_LAST) begin
                    if (m0_tx)
                        m0_sh <= {1'b1, m0_sh[7:1]};
                    m0_bit <= m0_bit + 3'h1;
                    if (m0_bit == 3'h7) begin
                        m0_busy   <= 1'b0;
                        m0_tx_evt <= m0_tx;
                        m0_rx_evt <= !m0_tx;
                    end
                end
            end
            m0_clk  <= !(m0_busy && mode0 && m0_ph <= `ASP_M0_HALF);
            rxd_out <= m0_sh[0];
            rxd_oe  <= m0_busy && m0_tx && mode0;
        end
    end

    // ----------------------------------------
    // txd pin: shift clock in mode 0, frame otherwise
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            txd <= 1'b1;
        else
            txd <= mode0 ? m0_clk : tx_line;
    end

    // ----------------------------------------
    // receive completion and flags
    // ----------------------------------------
    wire       rx_evt   = arx_evt | m0_rx_evt;
    wire [7:0] rx_data  = m0_rx_evt ? m0_sh : arx_data;
    wire       rx_9th   = arx_ninth;
    wire       rx_drop  = arx_evt && mode[1] && mp_en && !rx_9th;
    wire       rx_take  = rx_evt && !rx_drop && !stat[`ASP_ST_RXDONE];
    wire       rx_lost  = rx_evt && !rx_drop && stat[`ASP_ST_RXDONE];
    wire       tx_evt   = atx_evt | m0_tx_evt;
    wire [2:0] st_set   = {rx_lost, tx_evt, rx_take};
    wire [2:0] st_clr   = (wr_en && addr == `ASP_OFS_STAT) ? wr_data[2:0] : 3'h0;
    // set wins over a clear in the same cycle
    wire [2:0] next_stat = (stat & ~st_clr) | st_set;

    // ----------------------------------------
    // sticky status flags, one flop per event
    // ----------------------------------------
    localparam [2:0] stat_rst = `ASP_STAT_RST;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
            reg flag;
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n)
                    flag <= stat_rst[gi];
                else
                    flag <= next_stat[gi];
            end
            assign stat[gi] = flag;
        end
    endgenerate

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl         <= `ASP_CTRL_RST;
            mask         <= `ASP_MASK_RST;
            baud         <= `ASP_BAUD_RST;
            rx_buf       <= 8'h00;
            rx_ninth_bit <= 1'b0;
            irq          <= 1'b0;
        end else begin
            irq  <= |(next_stat & mask);
            if (wr_en) begin
                case (addr)
                    `ASP_OFS_CTRL: ctrl <= wr_data;
                    `ASP_OFS_MASK: mask <= wr_data[2:0];
                    `ASP_OFS_BAUD: baud <= wr_data;
                    default: ;
                endcase
            end
            // older byte kept; newer one is the one lost
            if (rx_take) begin
                rx_buf <= rx_data;
                if (arx_evt)
                    rx_ninth_bit <= rx_9th;
            end
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `ASP_OFS_CTRL: rd_data <= {ctrl[7:3], rx_ninth_bit, ctrl[1:0]};
                `ASP_OFS_BUF:  rd_data <= rx_buf;
                `ASP_OFS_STAT: rd_data <= {5'h00, stat};
                `ASP_OFS_MASK: rd_data <= {5'h00, mask};
                `ASP_OFS_BAUD: rd_data <= baud;
                default:       rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

endmodule

// [tb/asp_serial_port_asserts.sv]
// checker on the serial port top ports: read port, mode 0 clock, irq
// assumes: bound to asp_serial_port, clk_sys single domain, rst_n async low
`timescale 1ns/1ps
module asp_serial_port_asserts (
    input wire       clk_sys,
    input wire       rst_n,
    input wire [2:0] addr,
    input wire [7:0] wr_data,
    input wire       wr_en,
    input wire       rd_en,
    input wire [7:0] rd_data,
    input wire       rxd_in,
    input wire       rxd_out,
    input wire       rxd_oe,
    input wire       txd,
    input wire       irq
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    reg [3:0] n_fall;
    reg       txd_q;
    reg [3:0] buf_wr;
    // counts shift clock pulses of one mode 0 transmit burst
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_fall <= 4'h0;
            txd_q  <= 1'b1;
            buf_wr <= 4'h0;
        end else begin
            txd_q  <= txd;
            buf_wr <= {buf_wr[2:0], wr_en && addr == 3'h1};
            n_fall <= !rxd_oe ? 4'h0 : n_fall + {3'h0, txd_q & ~txd};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property ($past(rd_en) && $past(addr) > 3'h4 |-> rd_data == 8'h00)
        else $error("unmapped read returned data");
    a_m0_low_phase: assert property ($fell(txd) && rxd_oe |-> (!txd)[*6] ##1 txd)
        else $error("mode 0 clock low phase not six cycles");
    a_m0_data_hold: assert property ($rose(txd) && rxd_oe |-> $stable(rxd_out)[*5])
        else $error("mode 0 data moved during clock high");
    a_m0_eight_pulses: assert property ($fell(rxd_oe) |-> n_fall == 4'h8)
        else $error("mode 0 burst not eight clocks");
    a_oe_end_idle: assert property ($fell(rxd_oe) |-> txd)
        else $error("shift clock not idle high after burst");
    a_irq_clear_cause: assert property ($fell(irq) |-> $past(wr_en) || $past(wr_en, 2))
        else $error("irq dropped without software write");
    a_oe_after_write: assert property ($rose(rxd_oe) |-> buf_wr != 4'h0)
        else $error("mode 0 transmit without buffer write");
endmodule
bind asp_serial_port asp_serial_port_asserts u_asp_serial_port_asserts (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd), .irq(irq));

// [tb/asp_remote_node.sv]
// remote serial node and mode 0 shift register on the port's pins
// assumes: clk_sys shared with the port, tasks called from tb
`timescale 1ns/1ps
module asp_remote_node (
    input wire clk_sys,
    input wire txd,
    input wire rxd_oe,
    input wire rxd_out,
    output wire line
);
    reg       m0      = 1'b0;
    reg       t_q     = 1'b1;
    reg [7:0] sh      = 8'hff;
    reg [7:0] seed    = 8'hff;
    reg [7:0] m0_got  = 8'h00;
    reg       a_line  = 1'b1;
    reg       m0_line = 1'b1;
    // released line idles high in both roles
    assign line = m0 ? m0_line : a_line;
    // ----------------------------------------
    // async frames, lsb first
    // ----------------------------------------
    task send(input [10:0] bits, input integer n, input integer bitc);
        integer i;
        begin
            @(posedge clk_sys);
            for (i = 0; i < n; i = i + 1) begin
                a_line <= bits[i];
                repeat (bitc) @(posedge clk_sys);
            end
            a_line <= 1'b1;
        end
    endtask
    task recv(input integer n, input integer bitc, output [10:0] got);
        integer i;
        begin
            got = 11'h000;
            i = 0;
            while (txd !== 1'b0 && i < 2000) begin
                @(posedge clk_sys);
                i = i + 1;
            end
            // sample mid bit to tolerate a cycle of skew
            repeat (bitc / 2) @(posedge clk_sys);
            for (i = 0; i < n; i = i + 1) begin
                got[i] = txd;
                repeat (bitc) @(posedge clk_sys);
            end
        end
    endtask
    // ----------------------------------------
    // mode 0 shift register: capture on rise, shift out on fall
    // ----------------------------------------
    always @(posedge clk_sys) begin
        t_q <= txd;
        if (txd && !t_q && rxd_oe)
            m0_got <= {rxd_out, m0_got[7:1]};
        if (!m0)
            sh <= seed;
        else if (!txd && t_q && !rxd_oe) begin
            m0_line <= sh[0];
            sh      <= {1'b1, sh[7:1]};
        end
    end
endmodule

// [tb/tb.sv]
// self-checking bench: register port tasks and serial scenarios
// assumes: asp_serial_port with remote node model on its pins
`timescale 1ns/1ps
module tb;
    reg         clk_sys    = 1'b0;
    reg         rst_n      = 1'b0;
    reg  [2:0]  addr       = 3'h0;
    reg  [7:0]  wr_data    = 8'h00;
    reg         wr_en      = 1'b0;
    reg         rd_en      = 1'b0;
    wire [7:0]  rd_data;
    wire        rxd_out;
    wire        rxd_oe;
    wire        txd;
    wire        irq;
    wire        line;
    wire        rxd_in     = rxd_oe ? rxd_out : line;
    integer     mismatches = 0;
    integer     n_tests    = 0;
    integer     cyc        = 0;
    integer     i;
    reg  [10:0] fr;
    reg  [7:0]  q;
    reg  [7:0]  cv;

    asp_serial_port u_asp_serial_port (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .irq(irq));
    asp_remote_node u_asp_remote_node (.clk_sys(clk_sys), .txd(txd), .rxd_oe(rxd_oe),
        .rxd_out(rxd_out), .line(line));

    initial forever #12.5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task conclude;
        begin
            $display("tests %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            conclude;
        end
    end
    task chk(input [10:0] got, input [10:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            addr    <= a;
            wr_data <= d;
            wr_en   <= 1'b1;
            @(posedge clk_sys);
            wr_en   <= 1'b0;
        end
    endtask
    task rd(input [2:0] a, output [7:0] d);
        begin
            @(posedge clk_sys);
            addr  <= a;
            rd_en <= 1'b1;
            @(posedge clk_sys);
            rd_en <= 1'b0;
            #1 d = rd_data;
        end
    endtask
    task rdc(input [2:0] a, input [7:0] e);
        begin
            rd(a, q);
            chk({3'h0, q}, {3'h0, e});
        end
    endtask
    task wait_stat(input [7:0] m);
        integer k;
        begin
            q = 8'h00;
            for (k = 0; k < 1500 && (q & m) == 8'h00; k = k + 1)
                rd(3'h2, q);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
            if (i != 1)
                rdc(i[2:0], 8'h00);
        $display("test reset done");
        wr(3'h4, 8'h00);
        wr(3'h3, 8'h07);
        wr(3'h0, 8'h50);
        fork
            u_asp_remote_node.send({1'b0, 1'b1, 8'h3c, 1'b0}, 10, 16);
            wr(3'h1, 8'ha5);
            u_asp_remote_node.recv(10, 16, fr);
        join
        chk(fr, {2'b01, 8'ha5, 1'b0});
        wait_stat(8'h03);
        rdc(3'h2, 8'h03);
        rdc(3'h1, 8'h3c);
        rdc(3'h0, 8'h54);
        chk({10'h000, irq}, 11'h001);
        wr(3'h3, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk({10'h000, irq}, 11'h000);
        wr(3'h3, 8'h02);
        repeat (2) @(posedge clk_sys);
        chk({10'h000, irq}, 11'h001);
        wr(3'h2, 8'h03);
        repeat (2) @(posedge clk_sys);
        chk({10'h000, irq}, 11'h000);
        rdc(3'h2, 8'h00);
        $display("test mode1 done");
        fork
            begin
                u_asp_remote_node.send({2'b01, 8'h11, 1'b0}, 10, 16);
                u_asp_remote_node.send({2'b01, 8'h22, 1'b0}, 10, 16);
            end
            begin
                wait_stat(8'h01);
                rdc(3'h1, 8'h11);
                wr(3'h2, 8'h01);
            end
        join
        wait_stat(8'h01);
        rdc(3'h1, 8'h22);
        u_asp_remote_node.send({2'b01, 8'h33, 1'b0}, 10, 16);
        wait_stat(8'h04);
        rdc(3'h1, 8'h22);
        rdc(3'h2, 8'h05);
        wr(3'h2, 8'h07);
        wr(3'h0, 8'h40);
        u_asp_remote_node.send({2'b01, 8'h44, 1'b0}, 10, 16);
        repeat (20) @(posedge clk_sys);
        rdc(3'h2, 8'h00);
        $display("test overrun done");
        for (i = 0; i < 2; i = i + 1) begin
            cv = (i == 1) ? 8'h9a : 8'h98;
            wr(3'h0, cv);
            fork
                wr(3'h1, 8'h5a);
                u_asp_remote_node.recv(11, (i == 1) ? 32 : 64, fr);
            join
            chk(fr, {2'b11, 8'h5a, 1'b0});
            // stop bit sent low on purpose, it must be ignored
            u_asp_remote_node.send({2'b00, 8'hc6, 1'b0}, 11, (i == 1) ? 32 : 64);
            wait_stat(8'h01);
            rdc(3'h1, 8'hc6);
            rdc(3'h0, cv);
            wr(3'h2, 8'h07);
        end
        wr(3'h4, 8'h01);
        wr(3'h0, 8'hf0);
        u_asp_remote_node.send({2'b10, 8'h12, 1'b0}, 11, 32);
        repeat (20) @(posedge clk_sys);
        rdc(3'h2, 8'h00);
        u_asp_remote_node.send({2'b11, 8'h34, 1'b0}, 11, 32);
        wait_stat(8'h01);
        rdc(3'h1, 8'h34);
        rdc(3'h0, 8'hf4);
        wr(3'h2, 8'h07);
        $display("test mode2 mode3 done");
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h96);
        wait_stat(8'h02);
        chk({3'h0, u_asp_remote_node.m0_got}, 11'h096);
        wr(3'h2, 8'h07);
        u_asp_remote_node.seed = 8'hc3;
        wr(3'h0, 8'h10);
        u_asp_remote_node.m0 = 1'b1;
        wait_stat(8'h01);
        rdc(3'h1, 8'hc3);
        u_asp_remote_node.m0 = 1'b0;
        $display("test mode0 done");
        conclude;
    end
endmodule
